// ==== src/hps_map.vh ====
// Register map, field layout and timing constants for the hub port supervisor
`ifndef HPS_MAP_VH
`define HPS_MAP_VH
`define HPS_NPORT        8
`define HPS_CLK_MHZ      100
`define HPS_SLOT_US      140
`define HPS_SLOT_CYC     (`HPS_SLOT_US * `HPS_CLK_MHZ)
`define HPS_TTRIP_US     1000
`define HPS_TTRIP_CYC    (`HPS_TTRIP_US * `HPS_CLK_MHZ)
`define HPS_DEB_US       10000
`define HPS_DEB_CYC      (`HPS_DEB_US * `HPS_CLK_MHZ)
`define HPS_WDT_US       500000
`define HPS_WDT_CYC      (`HPS_WDT_US * `HPS_CLK_MHZ)
`define HPS_HB_UNIT_US   1000
`define HPS_HB_UNIT_CYC  (`HPS_HB_UNIT_US * `HPS_CLK_MHZ)
// Word addresses (byte address divided by four)
`define HPS_A_CTRL       4'h0
`define HPS_A_STATUS     4'h1
`define HPS_A_PEN        4'h2
`define HPS_A_OCFLAG     4'h3
`define HPS_A_HB         4'h4
`define HPS_A_LIMIT0     4'h8
// Control fields
`define HPS_C_AUTO       0
`define HPS_C_FORCE      1
`define HPS_C_USER       2
`define HPS_C_KICK       3
`define HPS_CTRL_RST     4'h1
`define HPS_HB_RST       8'h0a
`define HPS_LIMIT_RST    12'hfff
`endif

// ==== src/hps_top.v ====
// Hub port supervisor: overcurrent trip, upstream choice, link routing, indicators
`timescale 1ns/1ps
`include "hps_map.vh"
module hps_top #(
    parameter SLOT_CYC  = `HPS_SLOT_CYC,
    parameter TTRIP_CYC = `HPS_TTRIP_CYC,
    parameter DEB_CYC   = `HPS_DEB_CYC,
    parameter WDT_CYC   = `HPS_WDT_CYC,
    parameter HB_CYC    = `HPS_HB_UNIT_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Measurement converter: one raw result per slot, voltage and current slots alternating
    output reg  [2:0]  adc_port,
    output reg         adc_is_current,
    input  wire [11:0] adc_raw,
    // Upstream and control port status
    input  wire        upstream_zero_conn,
    input  wire        upstream_one_conn,
    input  wire        upstream_super,
    input  wire        ctrl_attach,
    input  wire        ctrl_enumerated,
    input  wire        fw_healthy,
    // Downstream status
    input  wire [7:0]  down_enum,
    input  wire [7:0]  down_super,
    // Switching outputs
    output reg  [7:0]  port_power,
    output wire        upstream_sel_one,
    output wire        upstream_grant_zero,
    output wire        upstream_grant_one,
    output wire        link_on_ctrl,
    output wire        ctrl_hub_data_en,
    // Indicators
    output wire        led_link,
    output reg         led_heartbeat,
    output wire        led_power_red,
    output reg         led_power_blue,
    output wire        led_up_green,
    output wire        led_up_yellow,
    output wire [7:0]  led_down_green,
    output wire [7:0]  led_down_yellow,
    output wire [7:0]  led_down_power,
    output wire        led_upstream_zero,
    output wire        led_upstream_one,
    output wire        led_ctrl,
    output reg         led_user
);

    // Software state
    reg  [3:0]  ctrl;
    reg  [7:0]  port_en;
    reg  [7:0]  oc_flag;
    reg  [7:0]  hb_rate;
    reg  [11:0] limit [0:`HPS_NPORT-1];
    reg         rd_pend;
    reg  [31:0] next_readdata;
    // Sequencer and trip state
    reg  [31:0] slot_cnt;
    reg  [1:0]  phase;
    reg  [2:0]  grp_base;
    reg  [31:0] trip_cnt [0:`HPS_NPORT-1];
    reg  [7:0]  trip_pend;
    // Debounce, watchdog, heartbeat
    reg         ctrl_stable;
    reg  [31:0] deb_cnt;
    reg  [31:0] wdt_cnt;
    reg         wdt_run;
    reg  [31:0] flash_cnt;
    reg  [31:0] hb_cnt;
    reg  [7:0]  hb_units;

    // Strobes decoded from the bus, the sequencer and the timers
    wire        slot_end;
    wire        wr_ctrl;
    wire        wr_ocflag;
    wire        wr_pen;
    wire        wr_kick;
    wire        sample_hit;
    wire        hb_tick;
    wire        up_sel_conn;
    wire        link_active;

    assign slot_end   = (slot_cnt == SLOT_CYC - 1);
    assign wr_ctrl    = avs_write && (avs_address == `HPS_A_CTRL);
    assign wr_ocflag  = avs_write && (avs_address == `HPS_A_OCFLAG);
    assign wr_pen     = avs_write && (avs_address == `HPS_A_PEN);
    assign wr_kick    = wr_ctrl && avs_writedata[`HPS_C_KICK];
    assign sample_hit = slot_end && adc_is_current;
    assign hb_tick    = (hb_cnt == HB_CYC - 1);

    // Reads answer one cycle after the request, writes at once
    assign avs_waitrequest = avs_read && !rd_pend;

    // Register writes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl    <= `HPS_CTRL_RST;
            port_en <= 8'h00;
            hb_rate <= `HPS_HB_RST;
        end else if (avs_write) begin
            case (avs_address)
                `HPS_A_CTRL: ctrl    <= avs_writedata[3:0];
                `HPS_A_PEN:  port_en <= avs_writedata[7:0];
                `HPS_A_HB:   hb_rate <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // User indicator: software only, no hardware state of its own
    always @(posedge clk or posedge rst) begin
        if (rst)
            led_user <= 1'b0;
        else if (wr_ctrl)
            led_user <= avs_writedata[`HPS_C_USER];
    end

    // Trip level table, 12 bits, 1 mA per step
    genvar gi;
    generate
        for (gi = 0; gi < `HPS_NPORT; gi = gi + 1) begin : g_lim
            always @(posedge clk or posedge rst) begin
                if (rst)
                    limit[gi] <= `HPS_LIMIT_RST;
                else if (avs_write && avs_address == `HPS_A_LIMIT0 + gi)
                    limit[gi] <= avs_writedata[11:0];
            end
        end
    endgenerate

    // Read data selection for the addressed register; unmapped reads 0
    always @* begin
        next_readdata = 32'h00000000;
        case (avs_address)
            `HPS_A_CTRL:   next_readdata = {28'h0000000, ctrl};
            `HPS_A_STATUS: next_readdata = {26'h0, ctrl_stable,
                           upstream_sel_one, upstream_one_conn,
                           upstream_zero_conn, wdt_run, link_on_ctrl};
            `HPS_A_PEN:    next_readdata = {24'h000000, port_en};
            `HPS_A_OCFLAG: next_readdata = {24'h000000, oc_flag};
            `HPS_A_HB:     next_readdata = {24'h000000, hb_rate};
            default: begin
                if (avs_address >= `HPS_A_LIMIT0)
                    next_readdata = {20'h00000, limit[avs_address[2:0]]};
            end
        endcase
    end

    // Read path: data registered, one wait state per read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pend      <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_pend <= avs_read && !rd_pend;
            if (avs_read && !rd_pend)
                avs_readdata <= next_readdata;
        end
    end

    // Slot sequencer: groups of three ports, voltage then current each
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_cnt       <= 32'h00000000;
            adc_port       <= 3'h0;
            adc_is_current <= 1'b0;
            phase          <= 2'h0;
            grp_base       <= 3'h0;
        end else begin
            if (slot_end)
                slot_cnt <= 32'h00000000;
            else
                slot_cnt <= slot_cnt + 32'h00000001;
            if (slot_end) begin
                adc_is_current <= ~adc_is_current;
                if (adc_is_current) begin
                    if (phase == 2'h2) begin
                        phase    <= 2'h0;
                        grp_base <= grp_base + 3'h3;
                        adc_port <= grp_base + 3'h3;
                    end else begin
                        phase    <= phase + 2'h1;
                        adc_port <= adc_port + 3'h1;
                    end
                end
            end
        end
    end

    // Per-port trip: single raw sample over limit, flag, delayed cut-off
    generate
        for (gi = 0; gi < `HPS_NPORT; gi = gi + 1) begin : g_trip
            // Raw sample over the port's level; cut when the delay has run
            wire over;
            wire cut;
            assign over = sample_hit && (adc_port == gi)
                          && (adc_raw > limit[gi]) && port_en[gi];
            assign cut  = trip_pend[gi] && (trip_cnt[gi] == TTRIP_CYC - 1);

            // Overcurrent flag: a trip wins over a clear in the same cycle
            always @(posedge clk or posedge rst) begin
                if (rst)
                    oc_flag[gi] <= 1'b0;
                else if (over)
                    oc_flag[gi] <= 1'b1;
                else if (wr_ocflag && avs_writedata[gi])
                    oc_flag[gi] <= 1'b0;
            end

            // Trip delay timer
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    trip_pend[gi] <= 1'b0;
                    trip_cnt[gi]  <= 32'h00000000;
                end else if (over && !trip_pend[gi]) begin
                    trip_pend[gi] <= 1'b1;
                    trip_cnt[gi]  <= 32'h00000000;
                end else if (trip_pend[gi]) begin
                    trip_pend[gi] <= !cut;
                    trip_cnt[gi]  <= trip_cnt[gi] + 32'h00000001;
                end
            end

            // Port switch: cut after the delay, held off while flagged
            always @(posedge clk or posedge rst) begin
                if (rst)
                    port_power[gi] <= 1'b0;
                else if (cut)
                    port_power[gi] <= 1'b0;
                else if (!trip_pend[gi] && !oc_flag[gi])
                    port_power[gi] <= port_en[gi];
                else if (wr_pen && !avs_writedata[gi])
                    port_power[gi] <= 1'b0;
            end
        end
    endgenerate

    // Control port attach debounce
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_stable <= 1'b0;
            deb_cnt     <= 32'h00000000;
        end else if (ctrl_attach == ctrl_stable) begin
            deb_cnt <= 32'h00000000;
        end else if (deb_cnt == DEB_CYC - 1) begin
            ctrl_stable <= ctrl_attach;
            deb_cnt     <= 32'h00000000;
        end else begin
            deb_cnt <= deb_cnt + 32'h00000001;
        end
    end

    // Upstream choice and link routing; aux port has no logic here
    assign upstream_sel_one = ctrl[`HPS_C_AUTO] ? !upstream_zero_conn
                              : ctrl[`HPS_C_FORCE];
    assign upstream_grant_zero = !upstream_sel_one;
    assign upstream_grant_one  = upstream_sel_one;
    assign link_on_ctrl        = ctrl_stable;
    assign ctrl_hub_data_en    = 1'b0;
    assign up_sel_conn = upstream_sel_one ? upstream_one_conn
                         : upstream_zero_conn;
    assign link_active = ctrl_enumerated && (link_on_ctrl || up_sel_conn);

    // Watchdog: kicked by software, runs for a fixed time after each kick
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_cnt <= 32'h00000000;
            wdt_run <= 1'b0;
        end else if (wr_kick) begin
            wdt_cnt <= 32'h00000000;
            wdt_run <= 1'b1;
        end else if (wdt_cnt == WDT_CYC - 1) begin
            wdt_run <= 1'b0;
        end else begin
            wdt_cnt <= wdt_cnt + 32'h00000001;
        end
    end

    // Free-running flash period for the blue indicator
    always @(posedge clk or posedge rst) begin
        if (rst)
            flash_cnt <= 32'h00000000;
        else if (flash_cnt == WDT_CYC - 1)
            flash_cnt <= 32'h00000000;
        else
            flash_cnt <= flash_cnt + 32'h00000001;
    end

    // Blue flashes only while the watchdog runs and firmware is healthy
    always @(posedge clk or posedge rst) begin
        if (rst)
            led_power_blue <= 1'b0;
        else if (!(wdt_run && fw_healthy))
            led_power_blue <= 1'b0;
        else if (flash_cnt == WDT_CYC - 1)
            led_power_blue <= ~led_power_blue;
    end

    // Heartbeat unit timer, held clear while no link is active
    always @(posedge clk or posedge rst) begin
        if (rst)
            hb_cnt <= 32'h00000000;
        else if (!link_active || hb_tick)
            hb_cnt <= 32'h00000000;
        else
            hb_cnt <= hb_cnt + 32'h00000001;
    end

    // Heartbeat: toggles every hb_rate units while link is active
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hb_units      <= 8'h00;
            led_heartbeat <= 1'b0;
        end else if (!link_active) begin
            hb_units      <= 8'h00;
            led_heartbeat <= 1'b0;
        end else if (hb_tick) begin
            if (hb_units + 8'h01 >= hb_rate) begin
                hb_units      <= 8'h00;
                led_heartbeat <= ~led_heartbeat;
            end else begin
                hb_units <= hb_units + 8'h01;
            end
        end
    end

    // Indicators
    assign led_link          = ctrl_enumerated;
    assign led_power_red     = 1'b1;
    assign led_up_green      = upstream_super;
    assign led_up_yellow     = !upstream_super && (upstream_zero_conn || upstream_one_conn);
    assign led_down_green    = down_enum & down_super;
    assign led_down_yellow   = down_enum & ~down_super;
    assign led_down_power    = port_power;
    assign led_upstream_zero = upstream_zero_conn;
    assign led_upstream_one  = upstream_one_conn;
    assign led_ctrl          = ctrl_stable;

endmodule // hps_top

// ==== test/hps_checker.sv ====
// Port checker for the hub port supervisor
`timescale 1ns/1ps
module hps_checker #(
    parameter SLOT_CYC = 14000
) (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Converter sequencing
    input wire       adc_is_current,
    // Routing
    input wire       upstream_sel_one,
    input wire       upstream_grant_zero,
    input wire       upstream_grant_one,
    input wire       ctrl_attach,
    input wire       link_on_ctrl,
    input wire       ctrl_hub_data_en,
    input wire       ctrl_enumerated,
    // Power and indicators
    input wire [7:0] port_power,
    input wire [7:0] down_enum,
    input wire [7:0] down_super,
    input wire [7:0] led_down_power,
    input wire [7:0] led_down_green,
    input wire [7:0] led_down_yellow,
    input wire       led_link,
    input wire       led_power_red,
    input wire       led_ctrl
);
    reg        prev_cur;
    reg        seen;
    reg [31:0] slot_cnt;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Cycles since the last slot boundary
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_cur <= 1'b0;
            seen     <= 1'b0;
            slot_cnt <= 32'h0;
        end else begin
            prev_cur <= adc_is_current;
            seen     <= seen | (adc_is_current != prev_cur);
            slot_cnt <= (adc_is_current != prev_cur) ? 32'h1 : slot_cnt + 32'h1;
        end
    end
    // Relations between outputs and their causes
    property p_slot; (adc_is_current != prev_cur) && seen |-> slot_cnt == SLOT_CYC; endproperty
    a_slot: assert property (p_slot) else $error("slot length wrong");
    property p_data; ctrl_hub_data_en == 1'b0; endproperty
    a_data: assert property (p_data) else $error("hub data on control port");
    property p_grant; (upstream_grant_zero != upstream_grant_one) && (upstream_grant_one == upstream_sel_one); endproperty
    a_grant: assert property (p_grant) else $error("upstream grant wrong");
    property p_dpow; led_down_power == port_power; endproperty
    a_dpow: assert property (p_dpow) else $error("power indicator wrong");
    property p_dspd; led_down_green == (down_enum & down_super) && led_down_yellow == (down_enum & ~down_super); endproperty
    a_dspd: assert property (p_dspd) else $error("speed indicator wrong");
    property p_deb; !$stable(link_on_ctrl) |-> $past(ctrl_attach, 4) == link_on_ctrl; endproperty
    a_deb: assert property (p_deb) else $error("route changed on unstable attach");
    property p_ctrl; led_ctrl == link_on_ctrl; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control indicator wrong");
    property p_link; led_link == ctrl_enumerated; endproperty
    a_link: assert property (p_link) else $error("link indicator wrong");
    property p_red; led_power_red == 1'b1; endproperty
    a_red: assert property (p_red) else $error("red power indicator dark");
    // Main scenarios reached
    c_trip: cover property ($fell(port_power[3]));
    c_route: cover property ($rose(link_on_ctrl));
    c_sel: cover property ($rose(upstream_sel_one));
endmodule // hps_checker
bind hps_top hps_checker #(.SLOT_CYC(SLOT_CYC)) u_hps_chk (
    .clk(clk), .rst(rst), .adc_is_current(adc_is_current), .upstream_sel_one(upstream_sel_one),
    .upstream_grant_zero(upstream_grant_zero), .upstream_grant_one(upstream_grant_one),
    .ctrl_attach(ctrl_attach), .link_on_ctrl(link_on_ctrl), .ctrl_hub_data_en(ctrl_hub_data_en),
    .ctrl_enumerated(ctrl_enumerated), .port_power(port_power), .down_enum(down_enum),
    .down_super(down_super), .led_down_power(led_down_power), .led_down_green(led_down_green),
    .led_down_yellow(led_down_yellow), .led_link(led_link), .led_power_red(led_power_red),
    .led_ctrl(led_ctrl)
);

// ==== test/hps_adc_model.sv ====
// Converter model: returns the load current of the port under conversion in current slots, a fixed code in voltage slots
`timescale 1ns/1ps
module hps_adc_model (
    // Converter selection
    input  wire [2:0]  adc_port,
    input  wire        adc_is_current,
    // Load table, twelve bits per port
    input  wire [95:0] load_ma,
    output wire [11:0] adc_raw
);
    // Current slots give the raw load in 1 mA steps, voltage slots a 5.1 V code
    assign adc_raw = adc_is_current ? load_ma[adc_port * 12 +: 12] : 12'h27d;
endmodule // hps_adc_model

// ==== test/testbench.sv ====
// Self-checking testbench for the hub port supervisor
`timescale 1ns/1ps
`include "hps_map.vh"
module testbench;
    localparam SLOT = 20, TTRIP = 50;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest, exp_sel;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0]  adc_port;
    logic [11:0] adc_raw;
    logic        adc_is_current, conn_zero, conn_one, up_super, attach, enumd, healthy;
    logic [7:0]  down_enum, down_super, port_power, ld_green, ld_yellow, ld_power;
    logic        sel_one, g0, g1, link_ctrl, hub_data, l_link, l_hb, l_red, l_blue;
    logic        l_upg, l_upy, l_uz, l_uo, l_ctrl, l_user;
    logic [95:0] load;
    int          miscompares, cmp_count, lim[8], tog_hb, tog_bl, cyc, last3;

    hps_top #(.SLOT_CYC(SLOT), .TTRIP_CYC(TTRIP), .DEB_CYC(10), .WDT_CYC(100), .HB_CYC(10)) i_dut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .adc_port(adc_port), .adc_is_current(adc_is_current),
        .adc_raw(adc_raw), .upstream_zero_conn(conn_zero), .upstream_one_conn(conn_one),
        .upstream_super(up_super), .ctrl_attach(attach), .ctrl_enumerated(enumd),
        .fw_healthy(healthy), .down_enum(down_enum), .down_super(down_super),
        .port_power(port_power), .upstream_sel_one(sel_one), .upstream_grant_zero(g0),
        .upstream_grant_one(g1), .link_on_ctrl(link_ctrl), .ctrl_hub_data_en(hub_data),
        .led_link(l_link), .led_heartbeat(l_hb), .led_power_red(l_red), .led_power_blue(l_blue),
        .led_up_green(l_upg), .led_up_yellow(l_upy), .led_down_green(ld_green),
        .led_down_yellow(ld_yellow), .led_down_power(ld_power), .led_upstream_zero(l_uz),
        .led_upstream_one(l_uo), .led_ctrl(l_ctrl), .led_user(l_user)
    );
    hps_adc_model i_adc (.adc_port(adc_port), .adc_is_current(adc_is_current),
        .load_ma(load), .adc_raw(adc_raw));

    // Clock, cycle count and indicator activity
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (adc_is_current && adc_port == 3'd3) last3 <= cyc;
    always @(l_hb) tog_hb++;
    always @(l_blue) tog_bl++;

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            tally_and_finish;
        end
    endtask
    // Run-length limit
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        {rst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 36'h0};
        {conn_zero, conn_one, up_super, attach, enumd, healthy} = 6'h0;
        {down_enum, down_super, load, cyc, last3} = '0;
        void'($urandom(32'h78cce659));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped places
        bus(1'b0, `HPS_A_CTRL, 0); chk(rd, `HPS_CTRL_RST);
        bus(1'b0, `HPS_A_HB, 0); chk(rd, `HPS_HB_RST);
        bus(1'b1, 4'h6, 32'hffff_ffff);
        bus(1'b0, 4'h6, 0); chk(rd, 0);
        // Random trip levels, loads at the level, port three just above
        for (int p = 0; p < 8; p++) begin
            bus(1'b0, 4'(8 + p), 0); chk(rd, `HPS_LIMIT_RST);
            lim[p] = (p == 3) ? $urandom % 4095 : $urandom % 4096;
            bus(1'b1, 4'(8 + p), lim[p]);
            load[p * 12 +: 12] <= (p == 3) ? lim[p] + 1 : lim[p];
            bus(1'b0, 4'(8 + p), 0); chk(rd, lim[p]);
        end
        bus(1'b1, `HPS_A_PEN, 32'hff);
        repeat (2) @(negedge clk);
        chk(port_power, 8'hff);
        for (int n = 0; n < 2000 && port_power[3] !== 1'b0; n++) @(negedge clk);
        chk(cyc - last3 >= TTRIP && cyc - last3 <= TTRIP + 4, 1);
        chk(port_power, 8'hf7);
        bus(1'b0, `HPS_A_OCFLAG, 0); chk(rd, 32'h08);
        // Tripped port stays off until its flag is cleared
        load <= '0;
        bus(1'b1, `HPS_A_PEN, 32'hff);
        repeat (400) @(negedge clk);
        chk(port_power, 8'hf7);
        bus(1'b1, `HPS_A_OCFLAG, 32'h08);
        repeat (3) @(negedge clk);
        chk(port_power, 8'hff);
        bus(1'b1, `HPS_A_PEN, 32'h0);
        repeat (2) @(negedge clk);
        chk(port_power, 8'h00);
        // Every upstream mode against every connection state
        for (int i = 0; i < 16; i++) begin
            conn_zero <= i[2];
            conn_one <= i[3];
            {up_super, down_enum, down_super} <= $urandom;
            bus(1'b1, `HPS_A_CTRL, {29'h0, i[0] ^ i[3], i[1], i[0]});
            bus(1'b0, `HPS_A_STATUS, 0);
            exp_sel = i[0] ? !i[2] : i[1];
            chk(sel_one, exp_sel);
            chk(rd[4:2], {exp_sel, i[3], i[2]});
            chk({l_user, l_uz, l_uo}, {i[0] ^ i[3], i[2], i[3]});
            chk({l_upg, l_upy}, {up_super, !up_super && (i[2] || i[3])});
            chk({ld_green, ld_yellow}, {down_enum & down_super, down_enum & ~down_super});
        end
        // Short attach glitch is ignored, a steady attach moves the route
        attach <= 1'b1;
        repeat (3) @(posedge clk);
        attach <= 1'b0;
        repeat (20) @(negedge clk);
        chk(link_ctrl, 0);
        @(posedge clk);
        attach <= 1'b1;
        for (int n = 0; n < 40 && link_ctrl !== 1'b1; n++) @(negedge clk);
        chk(link_ctrl, 1);
        bus(1'b0, `HPS_A_STATUS, 0); chk(rd[0], 1);
        // Heartbeat at the fastest rate and a watchdog kick
        enumd <= 1'b1;
        healthy <= 1'b1;
        bus(1'b1, `HPS_A_HB, 1);
        bus(1'b1, `HPS_A_CTRL, 32'h9);
        {tog_hb, tog_bl} = '0;
        repeat (400) @(negedge clk);
        chk({tog_hb > 1, tog_bl > 0, l_link}, 3'b111);
        tally_and_finish;
    end
endmodule // testbench
